// ### hw/clps_core_seq.sv
`timescale 1ns/1ps
module clps_core_seq
  import clps_pkg::*;
#(
  parameter int RAMP_CYC = CLPS_RAMP_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_set_valid,
  input wire logic [1:0] reg_set_req,
  input wire logic [1:0] halt_thread,
  input wire clps_wake_type wake_ev,
  input wire logic cluster_deep,
  output clps_core_ctl_type ctl,
  output clps_state_type state,
  output logic by_reg
);
  localparam int CW = $clog2(RAMP_CYC + 1);

  typedef struct packed {
    clps_state_type st;
    logic by_reg;
    logic [1:0] waiting;
    logic [CW-1:0] cnt;
    clps_core_ctl_type ctl;
  } clps_seq_type;

  clps_seq_type s_reg;
  clps_seq_type s_next;
  logic wake_any;

  assign wake_any = |wake_ev;

  always_comb begin
    s_next = s_reg;
    // per-thread wait is latched; an event releases both threads unless the core was put to sleep by register write
    s_next.waiting = s_reg.waiting | halt_thread;
    if (!s_reg.by_reg && wake_any) begin
      s_next.waiting = 2'h0;
    end
    unique case (s_reg.st)
      CLPS_RUN: begin
        if (reg_set_valid && reg_set_req == CLPS_REQ_LIGHT) begin
          s_next.st = CLPS_LIGHT;
          s_next.by_reg = 1'b1;
        end else if (reg_set_valid && reg_set_req == CLPS_REQ_DEEP) begin
          s_next.st = CLPS_DEEP;
          s_next.by_reg = 1'b1;
        end else if (&s_next.waiting) begin
          s_next.st = CLPS_DEEP;
          s_next.by_reg = 1'b0;
        end
      end
      CLPS_LIGHT: begin
        // only a register write from another core leaves a register-entered state
        if (reg_set_valid && reg_set_req == CLPS_REQ_RUN) begin
          s_next.st = CLPS_RUN;
          s_next.by_reg = 1'b0;
        end else if (reg_set_valid && reg_set_req == CLPS_REQ_DEEP) begin
          s_next.st = CLPS_DEEP;
        end
      end
      CLPS_DEEP: begin
        if (cluster_deep) begin
          s_next.st = CLPS_DEEP;
        end else if (s_reg.by_reg ? (reg_set_valid && reg_set_req == CLPS_REQ_RUN)
                                  : wake_any) begin
          s_next.st = CLPS_WAKE;
          s_next.cnt = CW'(RAMP_CYC);
          s_next.by_reg = 1'b0;
        end else if (s_reg.by_reg && reg_set_valid && reg_set_req == CLPS_REQ_LIGHT) begin
          s_next.st = CLPS_LIGHT;
        end
      end
      CLPS_WAKE: begin
        if (s_reg.cnt == '0) begin
          s_next.st = CLPS_RUN;
        end else begin
          s_next.cnt = s_reg.cnt - 1'b1;
        end
      end
      default: begin
        s_next.st = CLPS_RUN;
      end
    endcase
    unique case (s_next.st)
      CLPS_RUN: s_next.ctl = '{fetch_en: 1'b1, snoop_en: 1'b1, clk_en: 1'b1,
                              retention_voltage_gating: 1'b0};
      CLPS_LIGHT: s_next.ctl = '{fetch_en: 1'b0, snoop_en: 1'b1, clk_en: 1'b1,
                                retention_voltage_gating: 1'b0};
      CLPS_DEEP: s_next.ctl = '{fetch_en: 1'b0, snoop_en: 1'b0, clk_en: 1'b0,
                               retention_voltage_gating: 1'b1};
      default: s_next.ctl = '{fetch_en: 1'b0, snoop_en: 1'b0, clk_en: 1'b1,
                             retention_voltage_gating: 1'b0};
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{st: CLPS_RUN, by_reg: 1'b0, waiting: 2'h0, cnt: '0,
                 ctl: '{fetch_en: 1'b1, snoop_en: 1'b1, clk_en: 1'b1,
                        retention_voltage_gating: 1'b0}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign ctl = s_reg.ctl;
  assign state = s_reg.st;
  assign by_reg = s_reg.by_reg;
endmodule : clps_core_seq

// ### hw/clps_ctrl.sv
`timescale 1ns/1ps
// Function
// - in light nap a core stops fetching, still snoops its L1 and keeps all state.
// - in deep nap a core stops fetching and snooping, has all clocks off and sits at retention voltage.
// - a core leaving deep nap is back in full operation within about one hundred clocks.
// - a permitted core may pick any core and a low power state, and that core is placed in it unless statically disabled, waking or asleep by instruction.
// - a core put to sleep by register write cannot wake itself.
// - each thread's halt-until-event instruction is latched for that thread on its own; one halted thread leaves the core running.
// - a core asleep by instruction wakes on trigger, interrupt, doorbell, stash or snooped reservation.
// - the physical core enters deep nap once both threads have halted.
// - with all cores of a cluster in light nap and the L2 flushed, the cluster may enter deep nap.
// - units gate their own clocks whenever they have no work.
// - an auto-gated unit runs at full rate the cycle after work is dispatched to it.
// - software can stop the clocks of each unused block, cores included.
// - a statically disabled block is only re-clocked by chip reset.
// - after long transmit idleness the Ethernet path signals low power idle to the PHY.
// - the device carries a factory voltage code for software to program the regulator.
module clps_ctrl
  import clps_pkg::*;
#(
  parameter int NUM_CORES = CLPS_NUM_CORES,
  parameter int NUM_UNITS = CLPS_NUM_UNITS,
  parameter int LPI_IDLE_CYC = CLPS_LPI_IDLE_CYC,
  // arbitrary value, stands in for the per-part fuse contents
  parameter logic [CLPS_VID_W-1:0] FUSE_VID = 8'h5a
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pm_wr_allowed,
  input wire clps_pm_wr_type pm_wr,
  input wire logic [NUM_CORES-1:0][1:0] halt_thread,
  input wire clps_wake_type [NUM_CORES-1:0] wake_ev,
  input wire logic cluster_deep_req,
  input wire logic l2_flushed,
  input wire logic [NUM_UNITS-1:0] unit_busy,
  input wire logic [NUM_UNITS-1:0] unit_dispatch,
  input wire logic unit_dis_wr,
  input wire logic [NUM_UNITS-1:0] unit_dis_val,
  input wire logic tx_active,
  output clps_core_ctl_type [NUM_CORES-1:0] core_ctl,
  output clps_state_type [NUM_CORES-1:0] core_state,
  output logic cluster_deep,
  output logic l2_clk_en,
  output logic [NUM_UNITS-1:0] unit_clk_en,
  output logic [NUM_UNITS-1:0] unit_dis,
  output logic lpi_assert,
  output logic [CLPS_VID_W-1:0] factory_supply_voltage_code
);
  localparam int LW = $clog2(LPI_IDLE_CYC + 1);

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic cluster_deep;
    logic [NUM_UNITS-1:0] unit_dis;
    logic [NUM_UNITS-1:0] unit_clk_en;
    logic [LW-1:0] idle_cnt;
    logic lpi;
    logic [CLPS_VID_W-1:0] vid;
    logic vid_loaded;
    logic [1:0] tx_sync;
  } clps_top_type;

  clps_top_type t_reg;
  clps_top_type t_next;
  clps_core_ctl_type [NUM_CORES-1:0] seq_ctl;
  logic [NUM_CORES-1:0] all_light;
  logic [NUM_CORES-1:0] reg_sel;
  logic [NUM_CORES-1:0] core_by_reg;
  logic [NUM_CORES-1:0] static_off;

  //////////////////////////////////////////////////////////////////////////////
  // per-core sequencers; each core below NUM_UNITS maps onto the static disable bit of the same index, others have none
  for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
    assign reg_sel[c] = pm_wr.wr && pm_wr_allowed && (pm_wr.core == 2'(c));
    assign static_off[c] = (c < NUM_UNITS) ? t_reg.unit_dis[c] : 1'b0;
    clps_core_seq clps_core_seq_i (
      .clk(clk),
      .resetn(resetn),
      .reg_set_valid(reg_sel[c] && !static_off[c]),
      .reg_set_req(pm_wr.req),
      .halt_thread(halt_thread[c]),
      .wake_ev(wake_ev[c]),
      .cluster_deep(t_reg.cluster_deep),
      .ctl(seq_ctl[c]),
      .state(core_state[c]),
      .by_reg(core_by_reg[c])
    );
    assign all_light[c] = (core_state[c] == CLPS_LIGHT) && core_by_reg[c];
    // a statically disabled core loses its clock outright; cluster deep nap overrides all
    assign core_ctl[c].fetch_en = seq_ctl[c].fetch_en && !static_off[c] && !t_reg.cluster_deep;
    assign core_ctl[c].snoop_en = seq_ctl[c].snoop_en && !static_off[c] && !t_reg.cluster_deep;
    assign core_ctl[c].clk_en = seq_ctl[c].clk_en && !static_off[c] && !t_reg.cluster_deep;
    assign core_ctl[c].retention_voltage_gating = seq_ctl[c].retention_voltage_gating ||
                                                  t_reg.cluster_deep;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    t_next = t_reg;
    // cluster deep nap needs every core in light nap and a clean L2
    if (!t_reg.cluster_deep) begin
      t_next.cluster_deep = cluster_deep_req && l2_flushed && (&all_light);
    end else if (!cluster_deep_req) begin
      t_next.cluster_deep = 1'b0;
    end
    // disable bits only set; clearing needs chip reset
    if (unit_dis_wr) begin
      t_next.unit_dis = t_reg.unit_dis | unit_dis_val;
    end
    // work presented this cycle turns the clock on for the next one
    t_next.unit_clk_en = (unit_busy | unit_dispatch) & ~t_next.unit_dis;
    // tx pin is asynchronous: only the second stage feeds the idle counter
    t_next.tx_sync = {t_reg.tx_sync[0], tx_active};
    // long tx idleness raises low power idle, first activity drops it
    if (t_reg.tx_sync[1]) begin
      t_next.idle_cnt = '0;
      t_next.lpi = 1'b0;
    end else if (t_reg.idle_cnt == LW'(LPI_IDLE_CYC)) begin
      t_next.lpi = 1'b1;
    end else begin
      t_next.idle_cnt = t_reg.idle_cnt + 1'b1;
    end
    // fuse value is captured once after reset release, never in reset
    if (!t_reg.vid_loaded) begin
      t_next.vid = FUSE_VID;
      t_next.vid_loaded = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign cluster_deep = t_reg.cluster_deep;
  assign l2_clk_en = !t_reg.cluster_deep;
  assign unit_clk_en = t_reg.unit_clk_en;
  assign unit_dis = t_reg.unit_dis;
  assign lpi_assert = t_reg.lpi;
  assign factory_supply_voltage_code = t_reg.vid;
endmodule : clps_ctrl

// ### hw/clps_pkg.sv
package clps_pkg;
  localparam int CLPS_NUM_CORES = 4;
  localparam int CLPS_NUM_UNITS = 8;
  localparam int CLPS_VID_W = 8;
  // wake latency budget from deep nap, in platform clocks
  localparam int CLPS_WAKE_BUDGET_CLK = 100;
  localparam int CLPS_CLK_HZ = 20000000;
  localparam int CLPS_WAKE_BUDGET_NS = CLPS_WAKE_BUDGET_CLK * (1000000000 / CLPS_CLK_HZ);
  // supply ramp from retention back to nominal, kept well inside the budget
  localparam int CLPS_RAMP_NS = 2000;
  localparam int CLPS_RAMP_CYC = (CLPS_RAMP_NS * (CLPS_CLK_HZ / 1000000)) / 1000;
  localparam int CLPS_LPI_IDLE_US = 500;
  localparam int CLPS_LPI_IDLE_CYC = CLPS_LPI_IDLE_US * (CLPS_CLK_HZ / 1000000);
  localparam logic [1:0] CLPS_REQ_RUN = 2'h0;
  localparam logic [1:0] CLPS_REQ_LIGHT = 2'h1;
  localparam logic [1:0] CLPS_REQ_DEEP = 2'h2;

  typedef enum logic [2:0] {
    CLPS_RUN = 3'h0,
    CLPS_LIGHT = 3'h1,
    CLPS_DEEP = 3'h2,
    CLPS_WAKE = 3'h3
  } clps_state_type;

  typedef struct packed {
    logic fetch_en;
    logic snoop_en;
    logic clk_en;
    logic retention_voltage_gating;
  } clps_core_ctl_type;

  typedef struct packed {
    logic wr;
    logic [1:0] core;
    logic [1:0] req;
  } clps_pm_wr_type;

  typedef struct packed {
    logic ext_trigger;
    logic interrupt;
    logic doorbell;
    logic l1d_stash;
    logic resv_snoop_clear;
  } clps_wake_type;
endpackage : clps_pkg

// ### tb/clps_core_model.sv
`timescale 1ns/1ps
module clps_core_model
  import clps_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] sel,
  input wire logic [1:0] halt_cmd,
  input wire logic [2:0] wake_cmd,
  input wire logic flush_cmd,
  output logic [CLPS_NUM_CORES-1:0][1:0] halt_thread,
  output clps_wake_type [CLPS_NUM_CORES-1:0] wake_ev,
  output logic l2_flushed
);
  logic [2:0] flush_cnt;
  initial begin
    halt_thread = '0;
    wake_ev = '0;
    l2_flushed = 1'b0;
    flush_cnt = 3'h0;
  end
  always @(posedge clk) begin
    halt_thread <= '0;
    halt_thread[sel] <= halt_cmd;
    wake_ev <= '0;
    if (wake_cmd != 3'h0) begin
      wake_ev[sel] <= 5'h10 >> (wake_cmd - 3'h1);
    end
    // flush is slow on purpose so the cluster request is seen before the cache is clean
    flush_cnt <= flush_cmd ? flush_cnt + 3'(flush_cnt != 3'h4) : 3'h0;
    l2_flushed <= flush_cmd && flush_cnt == 3'h4;
  end
endmodule : clps_core_model

// ### tb/clps_ctrl_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module clps_ctrl_bench;
  import clps_pkg::*;
  logic clk = 0, resetn = 0, pm_wr_allowed = 1, cluster_deep_req = 0, unit_dis_wr = 0, tx_active = 1;
  logic flush_cmd = 0, cluster_deep, l2_clk_en, l2_flushed, lpi_assert;
  logic [1:0] sel = 0, halt_cmd = 0;
  logic [2:0] wake_cmd = 0;
  logic [7:0] unit_busy = '0, unit_dispatch = '0, unit_dis_val = '0, unit_clk_en, unit_dis, vcode;
  logic [3:0][1:0] halt_thread;
  clps_pm_wr_type pm_wr = '0;
  clps_wake_type [3:0] wake_ev;
  clps_core_ctl_type [3:0] core_ctl;
  clps_state_type [3:0] core_state;
  int errors = 0, total_checks = 0, n;
  always #25 clk = ~clk;
  clps_core_model clps_core_model_i (.clk(clk), .sel(sel), .halt_cmd(halt_cmd),
    .wake_cmd(wake_cmd), .flush_cmd(flush_cmd), .halt_thread(halt_thread), .wake_ev(wake_ev),
    .l2_flushed(l2_flushed));
  // short idle count keeps the low power idle scenario brief
  clps_ctrl #(.LPI_IDLE_CYC(20)) clps_ctrl_i (.clk(clk), .resetn(resetn),
    .pm_wr_allowed(pm_wr_allowed), .pm_wr(pm_wr), .halt_thread(halt_thread), .wake_ev(wake_ev),
    .cluster_deep_req(cluster_deep_req), .l2_flushed(l2_flushed), .unit_busy(unit_busy),
    .unit_dispatch(unit_dispatch), .unit_dis_wr(unit_dis_wr), .unit_dis_val(unit_dis_val),
    .tx_active(tx_active), .core_ctl(core_ctl), .core_state(core_state),
    .cluster_deep(cluster_deep), .l2_clk_en(l2_clk_en), .unit_clk_en(unit_clk_en),
    .unit_dis(unit_dis), .lpi_assert(lpi_assert), .factory_supply_voltage_code(vcode));
  //////////////////////////////////////////////////////////////////////////////
  task step;
    @(posedge clk);
    #1;
  endtask : step
  task conclude;
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task pm(input logic [1:0] c, input logic [1:0] r);
    pm_wr = '{1'b1, c, r};
    step;
    pm_wr.wr = 1'b0;
    // an idle edge between writes keeps each strobe a single clean pulse
    step;
  endtask : pm
  task waits(input int c, input clps_state_type s);
    n = 0;
    while (core_state[c] !== s && n < 120) begin
      step;
      n++;
    end
    if (core_state[c] !== s) begin
      errors++;
      conclude;
    end
  endtask : waits
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) step;
    resetn = 1;
    step;
    `CHK("vcode", 8'h5a, vcode)
    `CHK("ctl0", 4'he, core_ctl[0])
    pm_wr_allowed = 0;
    pm(1, CLPS_REQ_LIGHT);
    `CHK("refused", CLPS_RUN, core_state[1])
    pm_wr_allowed = 1;
    pm(1, CLPS_REQ_LIGHT);
    `CHK("light", CLPS_LIGHT, core_state[1])
    `CHK("lightctl", 4'h6, core_ctl[1])
    sel = 1;
    wake_cmd = 2;
    step;
    wake_cmd = 0;
    repeat (2) step;
    `CHK("selfwake", CLPS_LIGHT, core_state[1])
    pm(1, CLPS_REQ_RUN);
    `CHK("run", CLPS_RUN, core_state[1])
    pm(2, CLPS_REQ_DEEP);
    `CHK("deepctl", 4'h1, core_ctl[2])
    pm(2, CLPS_REQ_RUN);
    waits(2, CLPS_RUN);
    `CHK("wakecyc", 1'b1, n <= 100)
    sel = 0;
    // every wake source once, each after a split halt of the two threads
    for (int w = 1; w <= 5; w++) begin
      halt_cmd = 2'b01;
      step;
      halt_cmd = 0;
      repeat (3) step;
      `CHK("onehalt", CLPS_RUN, core_state[0])
      halt_cmd = 2'b10;
      step;
      halt_cmd = 0;
      waits(0, CLPS_DEEP);
      `CHK("bothhalt", 4'h1, core_ctl[0])
      wake_cmd = 3'(w);
      step;
      wake_cmd = 0;
      waits(0, CLPS_RUN);
      `CHK("woke", 4'he, core_ctl[0])
    end
    for (int c = 0; c < 4; c++) pm(2'(c), CLPS_REQ_LIGHT);
    cluster_deep_req = 1;
    flush_cmd = 1;
    step;
    `CHK("unflushed", 1'b0, cluster_deep)
    repeat (6) step;
    `CHK("cluster", 2'b10, {cluster_deep, l2_clk_en})
    cluster_deep_req = 0;
    flush_cmd = 0;
    repeat (3) step;
    `CHK("clusterexit", 1'b0, cluster_deep)
    for (int c = 0; c < 4; c++) pm(2'(c), CLPS_REQ_RUN);
    for (int c = 0; c < 4; c++) waits(c, CLPS_RUN);
    unit_dispatch = 8'h01;
    step;
    unit_dispatch = 0;
    `CHK("dispatch", 1'b1, unit_clk_en[0])
    repeat (4) step;
    `CHK("autogate", 1'b0, unit_clk_en[0])
    unit_busy = 8'h40;
    repeat (3) step;
    `CHK("busyclk", 8'h40, unit_clk_en)
    unit_busy = 0;
    step;
    `CHK("idlegate", 8'h00, unit_clk_en)
    unit_dis_val = 8'h28;
    unit_dis_wr = 1;
    step;
    unit_dis_val = 8'h02;
    unit_dispatch = 8'h20;
    step;
    unit_dispatch = 0;
    `CHK("disclk", 2'b00, {unit_clk_en[5], core_ctl[3].clk_en})
    `CHK("sticky", 8'h2a, unit_dis)
    unit_dis_wr = 0;
    tx_active = 0;
    repeat (15) step;
    `CHK("lpiearly", 1'b0, lpi_assert)
    repeat (15) step;
    `CHK("lpi", 1'b1, lpi_assert)
    tx_active = 1;
    repeat (4) step;
    `CHK("lpiexit", 1'b0, lpi_assert)
    conclude;
  end
endmodule : clps_ctrl_bench

// ### tb/clps_ctrl_monitor.sv
`timescale 1ns/1ps
module clps_ctrl_monitor
  import clps_pkg::*;
#(
  parameter int NUM_CORES = CLPS_NUM_CORES,
  parameter int NUM_UNITS = CLPS_NUM_UNITS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pm_wr_allowed,
  input wire clps_pm_wr_type pm_wr,
  input wire clps_wake_type [NUM_CORES-1:0] wake_ev,
  input wire logic cluster_deep_req,
  input wire logic l2_flushed,
  input wire logic [NUM_UNITS-1:0] unit_dispatch,
  input wire logic tx_active,
  input wire clps_core_ctl_type [NUM_CORES-1:0] core_ctl,
  input wire clps_state_type [NUM_CORES-1:0] core_state,
  input wire logic cluster_deep,
  input wire logic l2_clk_en,
  input wire logic [NUM_UNITS-1:0] unit_clk_en,
  input wire logic [NUM_UNITS-1:0] unit_dis,
  input wire logic lpi_assert
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_light_nap_ctl: assert property (
    core_state[1] == CLPS_LIGHT && !cluster_deep |-> core_ctl[1] == 4'h6)
    else $error("light nap controls wrong");
  a_deep_nap_ctl: assert property (
    core_state[2] == CLPS_DEEP && !cluster_deep |-> core_ctl[2] == 4'h1)
    else $error("deep nap controls wrong");
  a_wake_in_budget: assert property (
    core_state[2] == CLPS_DEEP ##1 core_state[2] == CLPS_WAKE |-> ##[1:99] core_state[2] == CLPS_RUN)
    else $error("deep nap exit too slow");
  a_write_refused: assert property (pm_wr.wr && !pm_wr_allowed |=> $stable(core_state))
    else $error("disallowed write took effect");
  a_reg_sleep_held: assert property (
    core_state[1] == CLPS_LIGHT && !pm_wr.wr && !cluster_deep_req |=> core_state[1] == CLPS_LIGHT)
    else $error("register nap left without write");
  a_inst_wake: assert property (
    core_state[0] == CLPS_DEEP && wake_ev[0] != 5'h0 && !cluster_deep_req |=> core_state[0] == CLPS_WAKE)
    else $error("wake event ignored");
  a_dispatch_clk: assert property (unit_dispatch[0] && !unit_dis[0] |=> unit_clk_en[0])
    else $error("unit clock late after dispatch");
  a_static_off: assert property (unit_dis[5] |=> unit_dis[5] && !unit_clk_en[5])
    else $error("disabled unit clocked");
  a_cluster_entry: assert property (
    $rose(cluster_deep) |-> $past(l2_flushed) && $past(cluster_deep_req) && !l2_clk_en)
    else $error("cluster deep entry wrong");
  a_lpi_activity: assert property (tx_active [*4] |=> !lpi_assert)
    else $error("idle signal kept during traffic");
endmodule : clps_ctrl_monitor
bind clps_ctrl clps_ctrl_monitor #(.NUM_CORES(NUM_CORES), .NUM_UNITS(NUM_UNITS)) clps_ctrl_monitor_i (
  .clk(clk), .resetn(resetn), .pm_wr_allowed(pm_wr_allowed), .pm_wr(pm_wr), .wake_ev(wake_ev),
  .cluster_deep_req(cluster_deep_req), .l2_flushed(l2_flushed), .unit_dispatch(unit_dispatch),
  .tx_active(tx_active), .core_ctl(core_ctl), .core_state(core_state),
  .cluster_deep(cluster_deep), .l2_clk_en(l2_clk_en), .unit_clk_en(unit_clk_en),
  .unit_dis(unit_dis), .lpi_assert(lpi_assert));
